// File: rwt_pkg.sv
// constants and types for the runaway watchdog and trap vector block
package rwt_pkg;
   // bus register byte offsets
   localparam logic [3:0] ADR_WDT_START = 4'h0;
   localparam logic [3:0] ADR_PROC_MODE0 = 4'h4;
   localparam logic [3:0] ADR_WDT_STATUS = 4'h8;
   localparam logic [3:0] ADR_PRIO_LEVEL = 4'hc;
   // field positions
   localparam int unsigned SOFT_RESET_BIT = 3;
   localparam int unsigned STAT_RUN_BIT = 0;
   localparam int unsigned STAT_PEND_BIT = 1;
   // watchdog counter
   localparam int unsigned WDT_W = 15;
   localparam logic [14:0] WDT_RELOAD = 15'h7fff;
   localparam int unsigned WDT_DIV_DEF = 16;
   // soft reset pulse length in clocks
   localparam int unsigned SRST_LEN_DEF = 4;
   // priority level
   localparam int unsigned IPL_W = 3;
   localparam logic [2:0] IPL_WDT = 3'h7;
   localparam logic [2:0] IPL_RESET = 3'h0;
   // fixed vector table
   localparam int unsigned VEC_W = 24;
   localparam logic [23:0] VEC_BASE = 24'hffffdc;
   localparam logic [3:0] VIDX_UND = 4'h0;
   localparam logic [3:0] VIDX_OVF = 4'h1;
   localparam logic [3:0] VIDX_BRK = 4'h2;
   localparam logic [3:0] VIDX_AMATCH = 4'h3;
   localparam logic [3:0] VIDX_WDT = 4'h5;
   localparam logic [3:0] VIDX_NMI = 4'h7;
   localparam logic [3:0] VIDX_RESET = 4'h8;

   typedef enum logic {
      WDT_IDLE,
      WDT_RUN
   } rwt_wdt_mode_type;

   // one-cycle trap events from the core, the watchdog and the nmi pin
   typedef struct packed {
      logic undefined_opcode_trap;
      logic ovf;
      logic break_trap_instruction;
      logic amatch;
      logic wdt;
      logic nmi;
   } rwt_trap_ev_type;

   // byte address of a fixed vector entry
   function automatic logic [23:0] vec_addr(input logic [3:0] idx);
      vec_addr = VEC_BASE + {18'h0, idx, 2'b00};
   endfunction
endpackage

// File: rwt_trap_unit.sv
// fixed-vector trap arbiter for software traps, nmi and watchdog
`timescale 1ns/1ps
`default_nettype none
module rwt_trap_unit (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire rwt_pkg::rwt_trap_ev_type ev_i,
   input wire logic overflow_flag_i,
   input wire logic ack_i,
   output logic req_o,
   output logic [23:0] vec_o,
   output logic [3:0] src_o
);
   typedef struct packed {
      rwt_pkg::rwt_trap_ev_type pend;
      logic req;
      logic [23:0] vec;
      logic [3:0] src;
   } rwt_trap_st_type;

   rwt_trap_st_type s_q, s_d;
   rwt_pkg::rwt_trap_ev_type clr;

   // pending capture, fixed priority pick, vector lookup
   always_comb begin
      s_d = s_q;
      clr = '0;
      if (ack_i && s_q.req) begin
         unique case (s_q.src)
            rwt_pkg::VIDX_UND: clr.undefined_opcode_trap = 1'b1;
            rwt_pkg::VIDX_OVF: clr.ovf = 1'b1;
            rwt_pkg::VIDX_BRK: clr.break_trap_instruction = 1'b1;
            rwt_pkg::VIDX_AMATCH: clr.amatch = 1'b1;
            rwt_pkg::VIDX_WDT: clr.wdt = 1'b1;
            rwt_pkg::VIDX_NMI: clr.nmi = 1'b1;
            default: clr = '0;
         endcase
      end
      // new events win over the clear
      s_d.pend = (s_q.pend & ~clr) | ev_i;
      s_d.pend.ovf = (s_q.pend.ovf & ~clr.ovf) | (ev_i.ovf & overflow_flag_i);
      // no mask or level input: watchdog and nmi always pass
      s_d.req = |s_d.pend;
      s_d.src = s_q.src;
      if (s_d.pend.undefined_opcode_trap) begin
         s_d.src = rwt_pkg::VIDX_UND;
      end else if (s_d.pend.ovf) begin
         s_d.src = rwt_pkg::VIDX_OVF;
      end else if (s_d.pend.break_trap_instruction) begin
         s_d.src = rwt_pkg::VIDX_BRK;
      end else if (s_d.pend.nmi) begin
         s_d.src = rwt_pkg::VIDX_NMI;
      end else if (s_d.pend.wdt) begin
         s_d.src = rwt_pkg::VIDX_WDT;
      end else if (s_d.pend.amatch) begin
         s_d.src = rwt_pkg::VIDX_AMATCH;
      end
      s_d.vec = rwt_pkg::vec_addr(s_d.src);
   end

   // state register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_q <= '0;
         s_q.src <= rwt_pkg::VIDX_RESET;
         s_q.vec <= rwt_pkg::vec_addr(rwt_pkg::VIDX_RESET);
      end else begin
         s_q <= s_d;
      end
   end

   assign req_o = s_q.req;
   assign vec_o = s_q.vec;
   assign src_o = s_q.src;
endmodule
`default_nettype wire

// File: rwt_watchdog.sv
// watchdog timer, software reset and priority level with wishbone slave
`timescale 1ns/1ps
`default_nettype none
module rwt_watchdog #(
   parameter int unsigned WDT_DIV = rwt_pkg::WDT_DIV_DEF,
   parameter int unsigned SRST_LEN = rwt_pkg::SRST_LEN_DEF
) (
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone classic slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [3:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // core trap events, same clock
   input wire logic break_trap_instruction_i,
   input wire logic undefined_opcode_trap_i,
   input wire logic overflow_trap_instruction_i,
   input wire logic flag_register_overflow_i,
   input wire logic addr_match_i,
   input wire logic int_ack_i,
   // asynchronous nmi pin
   input wire logic nmi_pin_i,
   // to the core
   output logic trap_req_o,
   output logic [23:0] trap_vec_o,
   output logic [3:0] trap_src_o,
   output logic wdt_irq_o,
   output logic soft_reset_o,
   output logic ram_clear_o,
   output logic [2:0] processor_priority_level_o
);
   localparam int unsigned DIV_W = (WDT_DIV > 1) ? $clog2(WDT_DIV) : 1;
   localparam int unsigned SR_W = (SRST_LEN > 1) ? $clog2(SRST_LEN) : 1;
   localparam logic [DIV_W-1:0] DIV_TOP = DIV_W'(WDT_DIV - 1);
   localparam logic [SR_W-1:0] SR_TOP = SR_W'(SRST_LEN - 1);

   typedef struct packed {
      rwt_pkg::rwt_wdt_mode_type mode;
      logic [14:0] cnt;
      logic [DIV_W-1:0] div;
      logic wdt_ev;
      logic wdt_pend;
      logic ack;
      logic [31:0] dat;
      logic srst_on;
      logic [SR_W-1:0] srst;
      logic [2:0] processor_priority_level;
      logic ram_clr;
      logic [1:0] nmi_sync;
      logic nmi_prev;
   } rwt_wd_st_type;

   rwt_wd_st_type s_q, s_d;
   rwt_pkg::rwt_trap_ev_type ev;
   logic acc;
   logic wr;
   logic wr_start;
   logic wr_mode;
   logic wr_ipl;
   logic wdt_taken;
   logic trap_req;
   logic [23:0] trap_vec;
   logic [3:0] trap_src;

   // trap events toward the arbiter
   always_comb begin
      ev = '0;
      ev.undefined_opcode_trap = undefined_opcode_trap_i;
      ev.break_trap_instruction = break_trap_instruction_i;
      ev.ovf = overflow_trap_instruction_i;
      ev.amatch = addr_match_i;
      ev.wdt = s_q.wdt_ev;
      ev.nmi = s_q.nmi_sync[1] & ~s_q.nmi_prev;
   end

   rwt_trap_unit u_trap (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ev_i(ev),
      .overflow_flag_i(flag_register_overflow_i),
      .ack_i(int_ack_i),
      .req_o(trap_req),
      .vec_o(trap_vec),
      .src_o(trap_src)
   );

   // bus decode
   assign acc = cyc_i & stb_i & ~s_q.ack;
   assign wr = acc & we_i;
   assign wr_start = wr & (adr_i == rwt_pkg::ADR_WDT_START);
   assign wr_mode = wr & (adr_i == rwt_pkg::ADR_PROC_MODE0) & sel_i[0];
   assign wr_ipl = wr & (adr_i == rwt_pkg::ADR_PRIO_LEVEL) & sel_i[0];
   assign wdt_taken = int_ack_i & trap_req & (trap_src == rwt_pkg::VIDX_WDT);

   // next state
   always_comb begin
      s_d = s_q;
      s_d.ack = acc;
      s_d.wdt_ev = 1'b0;
      s_d.ram_clr = 1'b0;
      s_d.nmi_sync = {s_q.nmi_sync[0], nmi_pin_i};
      s_d.nmi_prev = s_q.nmi_sync[1];

      // read data, unmapped reads as zero
      if (acc) begin
         unique case (adr_i)
            rwt_pkg::ADR_WDT_START: s_d.dat = {17'h0, s_q.cnt};
            rwt_pkg::ADR_WDT_STATUS: begin
               s_d.dat = 32'h0;
               s_d.dat[rwt_pkg::STAT_RUN_BIT] = (s_q.mode == rwt_pkg::WDT_RUN);
               s_d.dat[rwt_pkg::STAT_PEND_BIT] = s_q.wdt_pend;
            end
            rwt_pkg::ADR_PRIO_LEVEL: s_d.dat = {29'h0, s_q.processor_priority_level};
            default: s_d.dat = 32'h0;
         endcase
      end

      // prescaled down count with underflow request
      if (s_q.mode == rwt_pkg::WDT_RUN) begin
         if (s_q.div == '0) begin
            s_d.div = DIV_TOP;
            if (s_q.cnt == '0) begin
               s_d.wdt_ev = 1'b1;
               s_d.cnt = rwt_pkg::WDT_RELOAD;
            end else begin
               s_d.cnt = s_q.cnt - 15'h1;
            end
         end else begin
            s_d.div = s_q.div - DIV_W'(1);
         end
      end

      // any start write outside a soft reset pulse reloads and runs, data ignored
      if (wr_start) begin
         s_d.mode = rwt_pkg::WDT_RUN;
         s_d.cnt = rwt_pkg::WDT_RELOAD;
         s_d.div = DIV_TOP;
      end

      // sticky watchdog request, set wins over acceptance
      if (wdt_taken) begin
         s_d.wdt_pend = 1'b0;
      end
      if (s_q.wdt_ev) begin
         s_d.wdt_pend = 1'b1;
      end

      // soft reset starts on the edge after the write
      if (wr_mode && dat_i[rwt_pkg::SOFT_RESET_BIT]) begin
         s_d.srst_on = 1'b1;
         s_d.srst = SR_TOP;
      end else if (s_q.srst_on) begin
         if (s_q.srst == '0) begin
            s_d.srst_on = 1'b0;
         end else begin
            s_d.srst = s_q.srst - SR_W'(1);
         end
      end

      // core reset puts the watchdog back to idle
      if (s_q.srst_on) begin
         s_d.mode = rwt_pkg::WDT_IDLE;
         s_d.cnt = rwt_pkg::WDT_RELOAD;
         s_d.div = DIV_TOP;
         s_d.wdt_pend = 1'b0;
         s_d.wdt_ev = 1'b0;
      end

      // priority level: software write, forced by watchdog acceptance
      if (wr_ipl) begin
         s_d.processor_priority_level = dat_i[2:0];
      end
      if (wdt_taken) begin
         s_d.processor_priority_level = rwt_pkg::IPL_WDT;
      end
   end

   // state register; soft reset never clears ipl or ram
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_q <= '0;
         s_q.mode <= rwt_pkg::WDT_IDLE;
         s_q.cnt <= rwt_pkg::WDT_RELOAD;
         s_q.div <= DIV_TOP;
         s_q.processor_priority_level <= rwt_pkg::IPL_RESET;
         s_q.ram_clr <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // outputs, all from flops
   assign dat_o = s_q.dat;
   assign ack_o = s_q.ack;
   assign wdt_irq_o = s_q.wdt_pend;
   assign soft_reset_o = s_q.srst_on;
   assign ram_clear_o = s_q.ram_clr;
   assign processor_priority_level_o = s_q.processor_priority_level;
   assign trap_req_o = trap_req;
   assign trap_vec_o = trap_vec;
   assign trap_src_o = trap_src;
endmodule
`default_nettype wire

// File: rwt_chk.sv
// assertions on the watchdog block ports
`timescale 1ns/1ps
`default_nettype none
module rwt_chk #(
   parameter int unsigned SRST_LEN = 4
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [3:0] adr_i,
   input wire logic [31:0] dat_i,
   input wire logic ack_o,
   input wire logic break_trap_instruction_i,
   input wire logic undefined_opcode_trap_i,
   input wire logic overflow_trap_instruction_i,
   input wire logic flag_register_overflow_i,
   input wire logic int_ack_i,
   input wire logic trap_req_o,
   input wire logic [23:0] trap_vec_o,
   input wire logic [3:0] trap_src_o,
   input wire logic wdt_irq_o,
   input wire logic soft_reset_o,
   input wire logic ram_clear_o,
   input wire logic [2:0] processor_priority_level_o
);
   logic [7:0] srst_cnt_q;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // length of the soft reset pulse
   always_ff @(posedge clk_i) begin
      srst_cnt_q <= (rst_i || !soft_reset_o) ? 8'h0 : srst_cnt_q + 8'h1;
   end
   // bus request taken, and the soft reset write
   sequence take_s;
      cyc_i && stb_i && !ack_o;
   endsequence
   sequence srst_wr_s;
      take_s ##0 (we_i && adr_i == rwt_pkg::ADR_PROC_MODE0 && dat_i[rwt_pkg::SOFT_RESET_BIT]);
   endsequence
   bus_answer_a: assert property (take_s |=> ack_o ##1 !ack_o) else $error("bus answer late");
   srst_start_a: assert property (srst_wr_s |=> soft_reset_o) else $error("soft reset late");
   srst_len_a: assert property ($fell(soft_reset_o) |-> srst_cnt_q == SRST_LEN)
      else $error("soft reset length");
   ram_keep_a: assert property (soft_reset_o |-> !ram_clear_o) else $error("ram cleared");
   srst_idle_a: assert property (soft_reset_o |=> !wdt_irq_o) else $error("watchdog not idle");
   wdt_prio_a: assert property (int_ack_i && trap_req_o && trap_src_o == rwt_pkg::VIDX_WDT
      |=> processor_priority_level_o == 3'h7 && !wdt_irq_o) else $error("priority not raised");
   // request and trap pending appear on the same edge; only nmi may outrank it then
   wdt_src_a: assert property ($rose(wdt_irq_o) && !$past(trap_req_o)
      && !$past(break_trap_instruction_i) && !$past(undefined_opcode_trap_i) && !$past(overflow_trap_instruction_i)
      |-> trap_req_o && (trap_src_o == rwt_pkg::VIDX_NMI
      || (trap_src_o == rwt_pkg::VIDX_WDT && trap_vec_o == 24'hfffff0))) else $error("wdt vector");
   brk_trap_a: assert property (break_trap_instruction_i && !trap_req_o && !undefined_opcode_trap_i
      && !overflow_trap_instruction_i |=> trap_vec_o == 24'hffffe4) else $error("break vector");
   ovf_trap_a: assert property (overflow_trap_instruction_i && flag_register_overflow_i
      && !trap_req_o && !undefined_opcode_trap_i |=> trap_vec_o == 24'hffffe0) else $error("overflow vector");
   ovf_skip_a: assert property (overflow_trap_instruction_i && !flag_register_overflow_i && !trap_req_o
      && !undefined_opcode_trap_i && !break_trap_instruction_i && !wdt_irq_o |=> !trap_req_o)
      else $error("overflow trap taken");
endmodule
`default_nettype wire

// File: tb_top.sv
// self-checking bench for the watchdog and trap block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, ack_o, oflag = 1'b0, iack = 1'b0;
   logic trap_req_o, wdt_irq_o, soft_reset_o, ram_clear_o, nmi = 1'b0;
   logic [2:0] processor_priority_level;
   logic [3:0] ev = 4'h0, adr_i = 4'h0, trap_src_o;
   logic [23:0] trap_vec_o;
   logic [31:0] dat_i = 32'h0, dat_o, rd;
   int fail_count = 0, checks = 0, n;
   // clock at 5 ns period
   always #2.5 clk_i = ~clk_i;
   rwt_watchdog #(.WDT_DIV(1), .SRST_LEN(4)) u_dut (
      .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i(4'hf), .dat_i, .dat_o, .ack_o,
      .break_trap_instruction_i(ev[2]), .undefined_opcode_trap_i(ev[1]), .overflow_trap_instruction_i(ev[0]),
      .flag_register_overflow_i(oflag), .addr_match_i(ev[3]), .int_ack_i(iack), .nmi_pin_i(nmi),
      .trap_req_o, .trap_vec_o, .trap_src_o, .wdt_irq_o, .soft_reset_o, .ram_clear_o,
      .processor_priority_level_o(processor_priority_level)
   );
   // one classic wishbone cycle
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= d;
      @(posedge clk_i);
      while (ack_o !== 1'b1) @(posedge clk_i);
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      @(posedge clk_i);
   endtask
   // compare and count
   task automatic ck(input string nm, input logic [31:0] e, input logic [31:0] s);
      checks++;
      if (s !== e) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", nm, e, s);
      end
   endtask
   // pulse a trap event, check the vector, accept it
   task automatic trap(input logic [3:0] e, input logic f, input logic [3:0] idx, input logic [23:0] v);
      ev <= e;
      oflag <= f;
      @(posedge clk_i);
      ev <= 4'h0;
      @(posedge clk_i);
      // index 8 means no trap expected; the selector then keeps its last source
      ck("trap_req", {31'h0, idx != 4'h8}, {31'h0, trap_req_o});
      if (idx != 4'h8) begin
         ck("trap_src", {28'h0, idx}, {28'h0, trap_src_o});
         ck("trap_vec", {8'h0, v}, {8'h0, trap_vec_o});
      end
      iack <= (idx != 4'h8);
      @(posedge clk_i);
      iack <= 1'b0;
      @(posedge clk_i);
   endtask
   // print counts and verdict
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // main sequence
   initial begin
      repeat (5) @(posedge clk_i);
      ck("ram_clear", 32'h1, {31'h0, ram_clear_o});
      rst_i <= 1'b0;
      @(posedge clk_i);
      bus(1'b0, rwt_pkg::ADR_WDT_START, 32'h0);
      ck("count", 32'h7fff, rd);
      repeat (50) @(posedge clk_i);
      bus(1'b0, rwt_pkg::ADR_WDT_STATUS, 32'h0);
      ck("status", 32'h0, rd);
      bus(1'b0, 4'h2, 32'h0);
      ck("unmapped", 32'h0, rd);
      $display("test idle done");
      bus(1'b1, rwt_pkg::ADR_WDT_START, 32'h0);
      repeat (100) @(posedge clk_i);
      bus(1'b0, rwt_pkg::ADR_WDT_START, 32'h0);
      ck("running", 32'h1, {31'h0, rd < 32'h7fff});
      bus(1'b1, rwt_pkg::ADR_WDT_START, 32'h1234);
      bus(1'b0, rwt_pkg::ADR_WDT_START, 32'h0);
      ck("reload", 32'h1, {31'h0, rd > 32'h7ff0});
      n = 0;
      while (wdt_irq_o !== 1'b1) begin
         @(posedge clk_i);
         n++;
      end
      ck("period", 32'h1, {31'h0, n > 32755 && n < 32776});
      trap(4'h0, 1'b0, rwt_pkg::VIDX_WDT, 24'hfffff0);
      bus(1'b0, rwt_pkg::ADR_PRIO_LEVEL, 32'h0);
      ck("ipl", 32'h7, rd);
      bus(1'b1, rwt_pkg::ADR_PROC_MODE0, 32'h8);
      ck("soft_reset", 32'h1, {31'h0, soft_reset_o});
      ck("ram_kept", 32'h0, {31'h0, ram_clear_o});
      repeat (6) @(posedge clk_i);
      bus(1'b0, rwt_pkg::ADR_WDT_STATUS, 32'h0);
      ck("idle", 32'h0, rd);
      ck("soft_reset_end", 32'h0, {31'h0, soft_reset_o});
      bus(1'b0, rwt_pkg::ADR_PRIO_LEVEL, 32'h0);
      ck("ipl_kept", 32'h7, rd);
      $display("test watchdog done");
      trap(4'h4, 1'b0, rwt_pkg::VIDX_BRK, 24'hffffe4);
      trap(4'h2, 1'b0, rwt_pkg::VIDX_UND, 24'hffffdc);
      trap(4'h1, 1'b1, rwt_pkg::VIDX_OVF, 24'hffffe0);
      trap(4'h1, 1'b0, 4'h8, 24'hfffffc);
      trap(4'h8, 1'b0, rwt_pkg::VIDX_AMATCH, 24'hffffe8);
      // nmi pin passes two sync stages before the edge detect
      nmi <= 1'b1;
      repeat (2) @(posedge clk_i);
      trap(4'h0, 1'b0, rwt_pkg::VIDX_NMI, 24'hfffff8);
      $display("test traps done");
      wrap_up;
   end
   // cut a hang short
   initial begin
      #250000;
      fail_count++;
      wrap_up;
   end
endmodule
bind rwt_watchdog rwt_chk #(.SRST_LEN(SRST_LEN)) u_chk (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .dat_i,
   .ack_o, .break_trap_instruction_i, .undefined_opcode_trap_i, .overflow_trap_instruction_i,
   .flag_register_overflow_i, .int_ack_i, .trap_req_o, .trap_vec_o, .trap_src_o, .wdt_irq_o, .soft_reset_o,
   .ram_clear_o, .processor_priority_level_o);
`default_nettype wire
